// file: rbf_top.sv
// receive buffer one control register and buffer-full pin control
`timescale 1ns/100ps
`include "rbf_defines.svh"

// Overview of operation
// R1: mode 11 bypasses filters, stores any message
// R2: mode 10 takes filtered extended frames only
// R3: mode 01 takes filtered standard frames only
// R4: mode 00 takes any filtered valid frame
// R5: read-only filter index in control bits 2:0
// R6: codes 5..2 name filters five to two
// R7: codes 1,0 only when rollover enabled (mode 11 stores whatever index is offered, rollover or not)
// R8: mode bit clear: pin follows state bit
// R9: rollover keeps the original admitting filter index
// R10: function enable clear floats the pin
// R11: interrupt mode asserts on load; state reads zero
module rbf_top
   import rbf_pkg::*;
(
   input  wire logic               CLK,              // core clock, 250 MHz
   input  wire logic               RST_N,            // asynchronous reset, active low
   input  wire logic [7:0]         REG_ADDR,         // register address from serial port
   input  wire logic               REG_WR,           // write strobe, one cycle
   input  wire rbf_pkg::rbf_byte_t REG_WDATA,        // write data
   input  wire logic               REG_RD,           // read strobe, one cycle
   output logic [7:0]              REG_RDATA,        // read data, valid the cycle after REG_RD
   output logic                    REG_RVALID,       // read data valid pulse
   input  wire logic               FRM_DONE,         // valid frame offered to buffer one, pulse
   input  wire logic               FRM_EXT,          // frame carries extended identifier
   input  wire logic               FRM_RTR,          // frame is a remote request
   input  wire logic               FRM_HIT,          // some acceptance filter matched
   input  wire rbf_pkg::rbf_filt_t FRM_FILT,         // index of the matching filter
   input  wire logic               FRM_ROLL,         // frame rolled over from buffer zero
   input  wire logic               ROLLOVER_EN,      // rollover enable of buffer zero control
   input  wire logic               LOAD0,            // message loaded into buffer zero, pulse
   input  wire logic               FULL0_CLR,        // buffer zero freed by software, pulse
   input  wire logic               FULL1_CLR,        // buffer one freed by software, pulse
   output logic                    RECEIVE_BUFFER_ONE_LOAD,        // buffer one takes the frame, pulse
   output logic [1:0]              BF_PIN_O,         // buffer-full pin levels, index = buffer
   output logic [1:0]              BF_PIN_OE         // buffer-full pin drive enables
);

   // body sees the package types unqualified
   import rbf_pkg::*;

   // control state
   rbf_mode_t mode_q,    mode_d;
   rbf_filt_t hit_q,     hit_d;
   logic      rtr_q,     rtr_d;
   logic [1:0] pstate_q, pstate_d;
   logic [1:0] penable_q, penable_d;
   logic [1:0] pmode_q,  pmode_d;
   logic [1:0] full_q,   full_d;
   logic       load_q,   load_d;
   logic [7:0] rdata_q,  rdata_d;
   logic       rvalid_q, rvalid_d;
   logic [1:0] pin_o_q,  pin_o_d;
   logic [1:0] pin_oe_q, pin_oe_d;

   // decode and acceptance nets
   logic accept;
   logic wr_b1;
   logic wr_pin;
   logic [1:0] loaded;

   // acceptance check lives apart so the mode decode stays readable
   rbf_accept u_accept (
      .acceptance_mode (mode_q),
      .frm_ext         (FRM_EXT),
      .frm_hit         (FRM_HIT),
      .frm_filt        (FRM_FILT),
      .frm_roll        (FRM_ROLL),
      .rollover_enable (ROLLOVER_EN),
      .accept          (accept)
   );

   // write decode for the two registers
   assign wr_b1  = REG_WR && (REG_ADDR == `RBF_ADDR_RECEIVE_BUFFER_ONE_CTRL);
   assign wr_pin = REG_WR && (REG_ADDR == `RBF_ADDR_PIN_CTRL);
   assign loaded = {FRM_DONE && accept, LOAD0};

   // buffer one control: mode is writable, status fields follow each stored frame
   always_comb begin
      mode_d = mode_q;
      hit_d  = hit_q;
      rtr_d  = rtr_q;
      load_d = 1'b0;
      if (wr_b1) begin
         mode_d = rbf_mode_t'(REG_WDATA[`RBF_MODE_HI:`RBF_MODE_LO]);
      end
      // a frame in flight is judged by the mode seen before this write
      if (FRM_DONE && accept) begin
         load_d = 1'b1;
         hit_d  = FRM_FILT; // R5 R6 R9
         rtr_d  = FRM_RTR;
      end
   end

   // register the buffer one fields
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= RBF_MODE_ALL; // R4
         hit_q  <= `RBF_HIT_RESET;
         rtr_q  <= 1'b0;
         load_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         hit_q  <= hit_d;
         rtr_q  <= rtr_d;
         load_q <= load_d;
      end
   end

   // pin control fields are plainly writable; state bits read back zero in interrupt mode
   always_comb begin
      pstate_d  = pstate_q;
      penable_d = penable_q;
      pmode_d   = pmode_q;
      if (wr_pin) begin
         pstate_d  = {REG_WDATA[`RBF_PIN1_STATE_BIT],  REG_WDATA[`RBF_PIN0_STATE_BIT]};
         penable_d = {REG_WDATA[`RBF_PIN1_ENABLE_BIT], REG_WDATA[`RBF_PIN0_ENABLE_BIT]};
         pmode_d   = {REG_WDATA[`RBF_PIN1_MODE_BIT],   REG_WDATA[`RBF_PIN0_MODE_BIT]};
      end
   end

   // register the pin control fields
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pstate_q  <= `RBF_PIN_BITS_RESET;
         penable_q <= `RBF_PIN_BITS_RESET;
         pmode_q   <= `RBF_PIN_BITS_RESET;
      end else begin
         pstate_q  <= pstate_d;
         penable_q <= penable_d;
         pmode_q   <= pmode_d;
      end
   end

   // per-buffer full flag and pin driver; a load in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
         // clear pulse of this buffer
         logic clr;
         assign clr = (gi == 0) ? FULL0_CLR : FULL1_CLR;

         always_comb begin
            full_d[gi] = full_q[gi];
            if (clr) begin
               full_d[gi] = 1'b0;
            end
            if (loaded[gi]) begin
               full_d[gi] = 1'b1; // R11
            end
         end

         // pins are active low in interrupt mode, as an open interrupt line would be
         // digital level and enable come from stored fields, so they trail a write by one edge
         always_comb begin
            pin_oe_d[gi] = penable_q[gi]; // R10
            if (pmode_q[gi]) begin
               pin_o_d[gi] = !full_d[gi]; // R11
            end else begin
               pin_o_d[gi] = pstate_q[gi]; // R8
            end
         end
      end
   endgenerate

   // register full flags and pin drivers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         full_q   <= `RBF_PIN_BITS_RESET;
         pin_o_q  <= `RBF_PIN_BITS_RESET;
         pin_oe_q <= `RBF_PIN_BITS_RESET;
      end else begin
         full_q   <= full_d;
         pin_o_q  <= pin_o_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // read mux; unmapped addresses and unimplemented bits read zero
   always_comb begin
      rdata_d  = rdata_q;
      rvalid_d = REG_RD;
      if (REG_RD) begin
         rdata_d = `RBF_BYTE_ZERO;
         if (REG_ADDR == `RBF_ADDR_RECEIVE_BUFFER_ONE_CTRL) begin
            rdata_d[`RBF_MODE_HI:`RBF_MODE_LO] = mode_q;
            rdata_d[`RBF_RTR_BIT]              = rtr_q;
            rdata_d[`RBF_HIT_HI:`RBF_HIT_LO]   = hit_q; // R5
         end else if (REG_ADDR == `RBF_ADDR_PIN_CTRL) begin
            // state bits read zero while their pin is an interrupt pin
            rdata_d[`RBF_PIN1_STATE_BIT]  = pstate_q[1] && !pmode_q[1]; // R11
            rdata_d[`RBF_PIN0_STATE_BIT]  = pstate_q[0] && !pmode_q[0]; // R11
            rdata_d[`RBF_PIN1_ENABLE_BIT] = penable_q[1];
            rdata_d[`RBF_PIN0_ENABLE_BIT] = penable_q[0];
            rdata_d[`RBF_PIN1_MODE_BIT]   = pmode_q[1];
            rdata_d[`RBF_PIN0_MODE_BIT]   = pmode_q[0];
         end
      end
   end

   // register the read port
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rdata_q  <= `RBF_BYTE_ZERO;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // every output straight from a flip-flop
   assign REG_RDATA  = rdata_q;
   assign REG_RVALID = rvalid_q;
   assign RECEIVE_BUFFER_ONE_LOAD  = load_q;
   assign BF_PIN_O   = pin_o_q;
   assign BF_PIN_OE  = pin_oe_q;

endmodule

// file: rbf_defines.svh
// register offsets, field positions and reset values for the buffer one control block
`ifndef RBF_DEFINES_SVH
`define RBF_DEFINES_SVH

// register offsets on the internal register port
`define RBF_ADDR_PIN_CTRL     8'h0C
`define RBF_ADDR_RECEIVE_BUFFER_ONE_CTRL    8'h70

// buffer one control field positions
`define RBF_MODE_HI           6
`define RBF_MODE_LO           5
`define RBF_RTR_BIT           3
`define RBF_HIT_HI            2
`define RBF_HIT_LO            0

// pin control field positions
`define RBF_PIN1_STATE_BIT    5
`define RBF_PIN0_STATE_BIT    4
`define RBF_PIN1_ENABLE_BIT   3
`define RBF_PIN0_ENABLE_BIT   2
`define RBF_PIN1_MODE_BIT     1
`define RBF_PIN0_MODE_BIT     0

// reset values
`define RBF_MODE_RESET        2'h0
`define RBF_HIT_RESET         3'h0
`define RBF_PIN_BITS_RESET    2'h0
`define RBF_BYTE_ZERO         8'h00

// filter indices 0 and 1, which only rollover from buffer zero may report, and the last valid index
`define RBF_FILT_ZERO         3'h0
`define RBF_FILT_ONE          3'h1
`define RBF_FILT_LAST         3'h5

`endif

// file: rbf_pkg.sv
// types shared by the buffer one control block
package rbf_pkg;

   // acceptance mode encodings, as software writes them
   typedef enum logic [1:0] {
      RBF_MODE_ALL      = 2'h0,
      RBF_MODE_STANDARD = 2'h1,
      RBF_MODE_EXTENDED = 2'h2,
      RBF_MODE_ANY      = 2'h3
   } rbf_mode_t;

   typedef logic [2:0] rbf_filt_t;
   typedef logic [7:0] rbf_byte_t;

endpackage

// file: rbf_accept.sv
// acceptance decision for a message offered to receive buffer one
`timescale 1ns/100ps

module rbf_accept
   import rbf_pkg::*;
(
   input  wire rbf_pkg::rbf_mode_t acceptance_mode,  // current buffer one mode
   input  wire logic               frm_ext,          // frame has extended identifier
   input  wire logic               frm_hit,          // some filter matched
   input  wire rbf_pkg::rbf_filt_t frm_filt,         // index of matching filter
   input  wire logic               frm_roll,         // message rolled over from buffer zero
   input  wire logic               rollover_enable,  // rollover enable of buffer zero
   output logic                    accept            // buffer one takes the message
);

   logic filt_ok;

   // filters 0/1 belong to buffer zero; they count here only via rollover
   always_comb begin
      filt_ok = 1'b0;
      if (frm_hit && frm_filt <= `RBF_FILT_LAST) begin
         if (frm_filt == `RBF_FILT_ZERO || frm_filt == `RBF_FILT_ONE) begin
            filt_ok = frm_roll && rollover_enable; // R7 R9
         end else begin
            filt_ok = !frm_roll;
         end
      end
   end

   // mode decides which identifier formats are admitted
   always_comb begin
      unique case (acceptance_mode)
         RBF_MODE_ANY:      accept = 1'b1;                // R1
         RBF_MODE_EXTENDED: accept = filt_ok && frm_ext;  // R2
         RBF_MODE_STANDARD: accept = filt_ok && !frm_ext; // R3
         RBF_MODE_ALL:      accept = filt_ok;             // R4
      endcase
   end

endmodule

// file: rbf_frm_src.sv
// frame source standing in for the receive path ahead of buffer one
`timescale 1ns/100ps
module rbf_frm_src
   import rbf_pkg::*;
(
   input  wire logic       clk,      // core clock
   input  wire logic       go,       // bench asks for one frame
   input  wire logic [6:0] req,      // ext, rtr, hit, roll, filt
   output logic            frm_done, // one-cycle offer
   output logic            frm_ext,  // extended id
   output logic            frm_rtr,  // remote request
   output logic            frm_hit,  // filter matched
   output logic            frm_roll, // rolled over
   output rbf_pkg::rbf_filt_t frm_filt // filter index
);
   logic [6:0] f_q;
   // fields are only valid with the offer; between offers they invert so a stale sample shows
   always_ff @(posedge clk) begin
      frm_done <= go;
      f_q <= go ? req : ~f_q;
   end
   assign {frm_ext, frm_rtr, frm_hit, frm_roll, frm_filt} = f_q;
endmodule

// file: rbf_chk_props.sv
// concurrent checks on the buffer one control block ports
`timescale 1ns/100ps
module rbf_chk
   import rbf_pkg::*;
(
   input wire logic               CLK,         // clock
   input wire logic               RST_N,       // reset, active low
   input wire logic [7:0]         REG_ADDR,    // address
   input wire logic               REG_WR,      // write strobe
   input wire rbf_pkg::rbf_byte_t REG_WDATA,   // write data
   input wire logic               REG_RD,      // read strobe
   input wire logic [7:0]         REG_RDATA,   // read data
   input wire logic               REG_RVALID,  // read valid
   input wire logic               FRM_DONE,    // frame offer
   input wire logic               FRM_EXT,     // extended id
   input wire logic               FRM_HIT,     // filter matched
   input wire rbf_pkg::rbf_filt_t FRM_FILT,    // filter index
   input wire logic               FRM_ROLL,    // rolled over
   input wire logic               ROLLOVER_EN, // rollover enable
   input wire logic               RECEIVE_BUFFER_ONE_LOAD,   // buffer one load
   input wire logic [1:0]         BF_PIN_O,    // pin levels
   input wire logic [1:0]         BF_PIN_OE    // pin enables
);
   logic [1:0] m_q;
   logic [7:0] pc_q;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // shadow of the writable fields, updated on the same edge as the block
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         m_q <= 2'h0;
         pc_q <= 8'h00;
      end else if (REG_WR && REG_ADDR == 8'h70) m_q <= REG_WDATA[6:5];
      else if (REG_WR && REG_ADDR == 8'h0C) pc_q <= REG_WDATA;
   end
   a_mode_any: assert property (FRM_DONE && m_q == 2'h3 |=> RECEIVE_BUFFER_ONE_LOAD)
      else $error("mode any dropped a frame");
   a_id_kind: assert property (FRM_DONE && (m_q == 2'h1 && FRM_EXT || m_q == 2'h2 && !FRM_EXT) |=> !RECEIVE_BUFFER_ONE_LOAD)
      else $error("wrong identifier kind taken");
   a_no_hit: assert property (FRM_DONE && m_q != 2'h3 && !FRM_HIT |=> !RECEIVE_BUFFER_ONE_LOAD)
      else $error("unfiltered frame taken");
   a_low_index: assert property (FRM_DONE && m_q != 2'h3 && FRM_FILT < 3'h2 && !(FRM_ROLL && ROLLOVER_EN) |=> !RECEIVE_BUFFER_ONE_LOAD)
      else $error("low filter index without rollover");
   a_roll_take: assert property (FRM_DONE && m_q == 2'h0 && FRM_HIT && FRM_ROLL && ROLLOVER_EN && FRM_FILT < 3'h2 |=> RECEIVE_BUFFER_ONE_LOAD)
      else $error("rollover frame dropped");
   a_ctrl_read: assert property (REG_RD && REG_ADDR == 8'h70 |=> REG_RVALID && REG_RDATA[7] == 1'b0 && REG_RDATA[6:5] == $past(m_q))
      else $error("control read wrong");
   // pin drivers follow the stored pin fields one edge after a write
   a_pin_float: assert property (BF_PIN_OE == $past(pc_q[3:2]))
      else $error("pin enable wrong");
   a_digit_lvl: assert property ($past(pc_q[2]) && !$past(pc_q[0]) |-> BF_PIN_O[0] == $past(pc_q[4]))
      else $error("digital pin level wrong");
   a_int_low: assert property ($past(pc_q[1]) && RECEIVE_BUFFER_ONE_LOAD |-> !BF_PIN_O[1])
      else $error("interrupt pin not asserted");
   a_state_zero: assert property (REG_RD && REG_ADDR == 8'h0C && pc_q[0] |=> !REG_RDATA[4])
      else $error("state bit not zero");
endmodule
bind rbf_top rbf_chk u_rbf_chk (.*);

// file: testbench.sv
// self-checking bench for the buffer one control block
`timescale 1ns/100ps
module testbench;
   import rbf_pkg::*;
   logic       CLK, RST_N, REG_WR, REG_RD, LOAD0, FULL0_CLR, FULL1_CLR, ROLLOVER_EN, go;
   logic       REG_RVALID, FRM_DONE, FRM_EXT, FRM_RTR, FRM_HIT, FRM_ROLL, RECEIVE_BUFFER_ONE_LOAD;
   logic [7:0] REG_ADDR, REG_RDATA;
   rbf_byte_t  REG_WDATA;
   rbf_filt_t  FRM_FILT;
   logic [6:0] req;
   logic [1:0] BF_PIN_O, BF_PIN_OE;
   int         err_count, comparisons;
   rbf_top u_rbf_top (.CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA),
      .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .FRM_DONE(FRM_DONE), .FRM_EXT(FRM_EXT),
      .FRM_RTR(FRM_RTR), .FRM_HIT(FRM_HIT), .FRM_FILT(FRM_FILT), .FRM_ROLL(FRM_ROLL), .ROLLOVER_EN(ROLLOVER_EN),
      .LOAD0(LOAD0), .FULL0_CLR(FULL0_CLR), .FULL1_CLR(FULL1_CLR), .RECEIVE_BUFFER_ONE_LOAD(RECEIVE_BUFFER_ONE_LOAD), .BF_PIN_O(BF_PIN_O),
      .BF_PIN_OE(BF_PIN_OE));
   rbf_frm_src u_rbf_frm_src (.clk(CLK), .go(go), .req(req), .frm_done(FRM_DONE), .frm_ext(FRM_EXT),
      .frm_rtr(FRM_RTR), .frm_hit(FRM_HIT), .frm_roll(FRM_ROLL), .frm_filt(FRM_FILT));
   // 4 ns clock
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge CLK);
      REG_WR <= 1'b0;
      // pin outputs follow a write one edge later, so let that edge pass
      @(posedge CLK);
      #1;
   endtask
   // read data counts only when the valid pulse is there
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1;
      chk(REG_RVALID ? REG_RDATA : 8'hEE, exp);
   endtask
   task automatic frm(input logic [6:0] r, input logic exp);
      @(posedge CLK);
      go <= 1'b1;
      req <= r;
      @(posedge CLK);
      go <= 1'b0;
      @(posedge CLK);
      #1;
      chk({7'h00, RECEIVE_BUFFER_ONE_LOAD}, {7'h00, exp});
   endtask
   // reset values, then an unmapped address that must read zero
   task automatic t_reset();
      rd(8'h70, 8'h00);
      rd(8'h0C, 8'h00);
      rd(8'h33, 8'h00);
      chk({4'h0, BF_PIN_OE, BF_PIN_O}, 8'h00);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(8'h70, {1'b0, m[1:0], 5'h1F});
         for (int e = 0; e < 2; e++) frm({e[0], 3'h2, 3'h3}, m == 3 || m == 0 || m == e + 1);
         frm(7'h05, m == 3);
         rd(8'h70, {1'b0, m[1:0], 2'h0, m == 3 ? 3'h5 : 3'h3});
      end
   endtask
   task automatic t_index();
      wr(8'h70, 8'h00);
      for (int f = 5; f > 1; f--) begin
         frm({3'h3, 1'b0, f[2:0]}, 1'b1);
         rd(8'h70, {5'h01, f[2:0]});
      end
      frm(7'h19, 1'b0);
      frm(7'h10, 1'b0);
      frm(7'h16, 1'b0);
      @(posedge CLK);
      ROLLOVER_EN <= 1'b1;
      frm(7'h1B, 1'b0);
      frm(7'h19, 1'b1);
      rd(8'h70, 8'h01);
   endtask
   task automatic t_pins();
      wr(8'h0C, 8'hFC);
      chk({6'h00, BF_PIN_OE}, 8'h03);
      chk({6'h00, BF_PIN_O}, 8'h03);
      rd(8'h0C, 8'h3C);
      wr(8'h0C, 8'h2C);
      chk({6'h00, BF_PIN_O}, 8'h02);
      wr(8'h0C, 8'h30);
      chk({6'h00, BF_PIN_OE}, 8'h00);
      @(posedge CLK);
      FULL1_CLR <= 1'b1;
      @(posedge CLK);
      FULL1_CLR <= 1'b0;
      wr(8'h0C, 8'h3F);
      rd(8'h0C, 8'h0F);
      chk({6'h00, BF_PIN_O}, 8'h03);
      @(posedge CLK);
      LOAD0 <= 1'b1;
      @(posedge CLK);
      LOAD0 <= 1'b0;
      #1;
      chk({6'h00, BF_PIN_O}, 8'h02);
      frm(7'h13, 1'b1);
      chk({6'h00, BF_PIN_O}, 8'h00);
      // load and clear in one cycle: the load wins, a lone clear then frees the pin
      @(posedge CLK);
      FULL0_CLR <= 1'b1;
      LOAD0 <= 1'b1;
      @(posedge CLK);
      LOAD0 <= 1'b0;
      #1;
      chk({6'h00, BF_PIN_O}, 8'h00);
      @(posedge CLK);
      FULL0_CLR <= 1'b0;
      #1;
      chk({6'h00, BF_PIN_O}, 8'h01);
   endtask
   // main sequence, inputs quiet from time zero
   initial begin
      {REG_WR, REG_RD, LOAD0, FULL0_CLR, FULL1_CLR, ROLLOVER_EN, go, RST_N} = 8'h00;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      req = 7'h00;
      err_count = 0;
      comparisons = 0;
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      t_reset();
      t_modes();
      t_index();
      t_pins();
      close_out();
   end
   // watchdog well past the roughly 140 cycles the run needs
   initial begin
      repeat (4000) @(posedge CLK);
      err_count++;
      close_out();
   end
endmodule
